// ===== sdc_cmd_decoder.sv
// Command decoder and clock-enable state logic with AXI4-Lite registers
`timescale 1ns/100ps
module sdc_cmd_decoder
	import sdc_pkg::*;
#(
	parameter int BW = BANK_W,
	parameter int AW = ADDR_W
)(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          mem_reset_n,
	input  wire logic          chip_sel_n,
	input  wire logic          row_strobe_n,
	input  wire logic          col_strobe_n,
	input  wire logic          write_strobe_n,
	input  wire logic          clock_gate_input,
	input  wire logic          termination_ctrl,
	input  wire logic [BW-1:0] bnk_sel,
	input  wire logic [AW-1:0] addr,
	output sdc_event_type      cmd_event,
	output sdc_state_type      dev_state,
	output logic               dev_idle,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);

	sdc_pins_type            pin_raw;
	sdc_pins_type            pin;
	sdc_state_type           state_r;
	logic                    cke_prev_r;
	logic [BANK_CNT-1:0]     bank_open_r;
	logic [BANK_CNT-1:0]     bank_open_nxt;
	logic                    close_pend_nxt;
	logic                    any_open_nxt;
	sdc_pins_type            pin_q;
	logic [15:0]             mr_r [MR_CNT];
	logic                    close_pend_r;
	logic [BW-1:0]           close_bank_r;
	logic                    burst_busy;
	logic                    burst_done;
	logic                    renew_busy;
	logic                    exit_busy;
	logic [TMR_W-1:0]        burst_len;
	logic [TMR_W-1:0]        cke_cnt_r;
	logic                    illegal_r;
	logic                    cke_viol_r;
	logic                    init_cal_done_r;
	logic [15:0]             renew_cnt_r;
	logic [7:0]              long_cal_cnt_r;
	logic [7:0]              short_cal_cnt_r;
	logic [31:0]             ctrl_r;
	sdc_cmd_type             cmd;
	logic                    cmd_ok;
	logic                    act;
	logic                    banks_idle;
	logic                    powered;
	logic [1:0]              mr_bl;

	// Pins come from the controller's clock tree, so resample them first
	assign pin_raw = '{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
		clock_gate_input, termination_ctrl, bnk_sel, addr};

	// Sampler clears to zero; flipping makes zero the idle bus, so no
	// false command or enable edge follows reset
	sdc_sync #(.W($bits(sdc_pins_type))) u_pin_sync
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (pin_raw ^ PIN_IDLE),
		.q       (pin_q)
	);
	assign pin = sdc_pins_type'(pin_q ^ PIN_IDLE);

	assign banks_idle = (bank_open_r == '0) && !close_pend_r;
	assign powered = (state_r == ST_IDLE) || (state_r == ST_ACTIVE);
	assign dev_idle = banks_idle && !burst_busy && pin.clock_gate_input
		&& !exit_busy && !renew_busy && powered;
	assign mr_bl = mr_r[0][BL_LSB +: 2];

	// Termination level is deliberately absent from this decode
	always_comb
	begin
		cmd    = CMD_IDLE;
		cmd_ok = 1'b1;
		act    = 1'b1;
		if (!powered)
		begin
			// Only an enable rise leaves low power; other edges hold state
			if (pin.clock_gate_input && !cke_prev_r)
			begin
				if (state_r == ST_SELF_RENEW)
					cmd = CMD_SLEEP_EXIT;
				else
				begin
					cmd    = CMD_LOW_POWER_EXIT;
					cmd_ok = pin.chip_sel_n ||
						({pin.row_strobe_n, pin.col_strobe_n,
						pin.write_strobe_n} == 3'b111);
				end
			end
			else
				act = 1'b0;
		end
		else if (pin.chip_sel_n || !ctrl_r[0])
			cmd = CMD_UNSELECTED;
		else
		begin
			case ({pin.row_strobe_n, pin.col_strobe_n, pin.write_strobe_n})
				3'b000: cmd = CMD_MODE_REG_LOAD;
				3'b001: cmd = CMD_AUTO_RENEW;
				3'b010: cmd = pin.addr[AUTOCLOSE_BIT] ?
					CMD_ROW_CLOSE_ALL : CMD_ROW_CLOSE_ONE;
				3'b011: cmd = CMD_ROW_OPEN;
				3'b100: cmd = CMD_WRITE;
				3'b101: cmd = CMD_READ;
				3'b110: cmd = pin.addr[AUTOCLOSE_BIT] ?
					CMD_LONG_CAL : CMD_SHORT_CAL;
				3'b111: cmd = CMD_IDLE;
				default: cmd = CMD_IDLE;
			endcase
		end
		if (powered && !pin.clock_gate_input)
		begin
			// Enable low while powered: entry is chosen by the command decoded in the same cycle
			if (cmd == CMD_AUTO_RENEW)
			begin
				cmd    = CMD_SLEEP_ENTRY;
				cmd_ok = dev_idle || (banks_idle && !burst_busy);
			end
			else if (cmd == CMD_IDLE || cmd == CMD_UNSELECTED)
				cmd = CMD_LOW_POWER_ENTRY;
			else
				cmd_ok = 1'b0;
		end
		else if (powered)
		begin
			case (cmd)
				CMD_MODE_REG_LOAD: cmd_ok = banks_idle && !burst_busy;
				CMD_AUTO_RENEW: cmd_ok = banks_idle && !renew_busy;
				CMD_ROW_OPEN: cmd_ok = !bank_open_r[pin.bnk_sel];
				CMD_READ,
				CMD_WRITE: cmd_ok = bank_open_r[pin.bnk_sel]
					&& !burst_busy;
				default: cmd_ok = 1'b1;
			endcase
		end
	end

	// Chop pin is honoured only when mode word zero allows per-command choice
	always_comb
	begin
		case (mr_bl)
			BL_FIXED4: burst_len = TMR_W'(BC4_CYC);
			BL_PER_CMD: burst_len = pin.addr[CHOP_BIT] ?
				TMR_W'(BL8_CYC) : TMR_W'(BC4_CYC);
			default: burst_len = TMR_W'(BL8_CYC);
		endcase
	end

	wire logic do_cmd = act && cmd_ok;
	wire logic do_rw = do_cmd && (cmd == CMD_READ || cmd == CMD_WRITE);

	sdc_timer u_burst
	(
		.aclk        (aclk),
		.aresetn     (aresetn),
		.mem_reset_n (mem_reset_n),
		.start       (do_rw),
		.load        (burst_len),
		.busy        (burst_busy),
		.done        (burst_done)
	);

	sdc_timer u_renew
	(
		.aclk        (aclk),
		.aresetn     (aresetn),
		.mem_reset_n (mem_reset_n),
		.start       (do_cmd && cmd == CMD_AUTO_RENEW && powered),
		.load        (TMR_W'(REFRESH_CYC)),
		.busy        (renew_busy),
		.done        ()
	);

	sdc_timer u_exit
	(
		.aclk        (aclk),
		.aresetn     (aresetn),
		.mem_reset_n (mem_reset_n),
		.start       (do_cmd && (cmd == CMD_SLEEP_EXIT
			|| cmd == CMD_LOW_POWER_EXIT)),
		.load        (TMR_W'(EXIT_CYC)),
		.busy        (exit_busy),
		.done        ()
	);

	// Device state; the reset pin clears it without the clock
	always_ff @(posedge aclk or negedge mem_reset_n)
	begin
		if (!mem_reset_n)
		begin
			state_r    <= ST_IDLE;
			cke_prev_r <= 1'b1;
		end
		else if (!aresetn)
		begin
			state_r    <= ST_IDLE;
			cke_prev_r <= 1'b1;
		end
		else
		begin
			cke_prev_r <= pin.clock_gate_input;
			if (do_cmd)
			begin
				case (cmd)
					CMD_SLEEP_ENTRY: state_r <= ST_SELF_RENEW;
					CMD_LOW_POWER_ENTRY: state_r <= banks_idle ?
						ST_PD_PRECHARGE : ST_PD_ACTIVE;
					CMD_SLEEP_EXIT: state_r <= ST_IDLE;
					CMD_LOW_POWER_EXIT: state_r <= (bank_open_r != '0) ?
						ST_ACTIVE : ST_IDLE;
					default: state_r <= any_open_nxt ? ST_ACTIVE : ST_IDLE;
				endcase
			end
			else if (powered)
				state_r <= any_open_nxt ? ST_ACTIVE : ST_IDLE;
		end
	end

	// Open rows; auto-close waits for the burst to finish, never cuts it.
	// State reads the next occupancy so both move on the same edge.
	always_comb
	begin
		bank_open_nxt  = bank_open_r;
		close_pend_nxt = close_pend_r;
		if (burst_done && close_pend_r)
		begin
			bank_open_nxt[close_bank_r] = 1'b0;
			close_pend_nxt              = 1'b0;
		end
		if (do_cmd)
		begin
			case (cmd)
				CMD_ROW_OPEN: bank_open_nxt[pin.bnk_sel] = 1'b1;
				CMD_ROW_CLOSE_ONE: bank_open_nxt[pin.bnk_sel] = 1'b0;
				CMD_ROW_CLOSE_ALL: bank_open_nxt = '0;
				CMD_READ,
				CMD_WRITE: close_pend_nxt = pin.addr[AUTOCLOSE_BIT];
				default: ;
			endcase
		end
		any_open_nxt = (bank_open_nxt != '0) || close_pend_nxt;
	end

	always_ff @(posedge aclk or negedge mem_reset_n)
	begin
		if (!mem_reset_n)
		begin
			bank_open_r  <= '0;
			close_pend_r <= 1'b0;
			close_bank_r <= '0;
		end
		else if (!aresetn)
		begin
			bank_open_r  <= '0;
			close_pend_r <= 1'b0;
			close_bank_r <= '0;
		end
		else
		begin
			bank_open_r  <= bank_open_nxt;
			close_pend_r <= close_pend_nxt;
			if (do_rw)
				close_bank_r <= pin.bnk_sel;
		end
	end

	// Mode registers
	always_ff @(posedge aclk or negedge mem_reset_n)
	begin
		if (!mem_reset_n)
			mr_r <= '{default: MR_RESET};
		else if (!aresetn)
			mr_r <= '{default: MR_RESET};
		else if (do_cmd && cmd == CMD_MODE_REG_LOAD)
			mr_r[pin.bnk_sel[1:0]] <= pin.addr[15:0];
	end

	// Refresh and calibration bookkeeping
	always_ff @(posedge aclk or negedge mem_reset_n)
	begin
		if (!mem_reset_n)
		begin
			init_cal_done_r <= 1'b0;
			renew_cnt_r     <= '0;
			long_cal_cnt_r  <= '0;
			short_cal_cnt_r <= '0;
		end
		else if (!aresetn)
		begin
			init_cal_done_r <= 1'b0;
			renew_cnt_r     <= '0;
			long_cal_cnt_r  <= '0;
			short_cal_cnt_r <= '0;
		end
		else if (do_cmd)
		begin
			if (cmd == CMD_AUTO_RENEW)
				renew_cnt_r <= renew_cnt_r + 16'h0001;
			if (cmd == CMD_LONG_CAL)
			begin
				if (init_cal_done_r)
					long_cal_cnt_r <= long_cal_cnt_r + 8'h01;
				init_cal_done_r <= 1'b1;
			end
			if (cmd == CMD_SHORT_CAL)
				short_cal_cnt_r <= short_cal_cnt_r + 8'h01;
		end
	end

	// Sticky errors; a new fault beats a same-cycle software clear
	wire logic err_wr;
	wire logic [31:0] err_wdata;
	always_ff @(posedge aclk or negedge mem_reset_n)
	begin
		if (!mem_reset_n)
		begin
			illegal_r  <= 1'b0;
			cke_viol_r <= 1'b0;
			cke_cnt_r  <= '0;
		end
		else if (!aresetn)
		begin
			illegal_r  <= 1'b0;
			cke_viol_r <= 1'b0;
			cke_cnt_r  <= '0;
		end
		else
		begin
			if (pin.clock_gate_input != cke_prev_r)
				cke_cnt_r <= TMR_W'(1);
			else if (cke_cnt_r != TMR_W'(CKE_MIN_EDGES))
				cke_cnt_r <= cke_cnt_r + TMR_W'(1);
			if (act && !cmd_ok)
				illegal_r <= 1'b1;
			else if (err_wr && err_wdata[0])
				illegal_r <= 1'b0;
			if (pin.clock_gate_input != cke_prev_r && cke_cnt_r != '0
				&& cke_cnt_r < TMR_W'(CKE_MIN_EDGES))
				cke_viol_r <= 1'b1;
			else if (err_wr && err_wdata[1])
				cke_viol_r <= 1'b0;
		end
	end

	// Registered command report; idle and unselected are reported too
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cmd_event <= '0;
		else
			cmd_event <= '{valid: act, legal: cmd_ok, cmd: cmd,
				bank: pin.bnk_sel, addr: pin.addr,
				eight_beat: (burst_len == TMR_W'(BL8_CYC))};
	end
	assign dev_state = state_r;

	// AXI4-Lite slave; address and data may arrive in either order
	logic        aw_full_r;
	logic        w_full_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic        wr_go;
	assign s_axi_awready = !aw_full_r;
	assign s_axi_wready  = !w_full_r;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go     = aw_full_r && w_full_r && !s_axi_bvalid;
	assign err_wr    = wr_go && aw_addr_r == OFF_ERR && w_data_r != '0;
	assign err_wdata = w_data_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_r    <= 1'b0;
			w_full_r     <= 1'b0;
			aw_addr_r    <= '0;
			w_data_r     <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			ctrl_r       <= CTRL_RESET;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_r)
			begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r)
			begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
			end
			if (wr_go)
			begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_r == OFF_CTRL || aw_addr_r == OFF_ERR)
					? RESP_OKAY : RESP_SLVERR;
				if (aw_addr_r == OFF_CTRL && s_axi_wstrb[0])
					ctrl_r[0] <= w_data_r[0];
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				OFF_CTRL: s_axi_rdata <= ctrl_r;
				OFF_STATUS: s_axi_rdata <= {12'h000, bank_open_r,
					3'h0, pin.termination_ctrl, exit_busy, renew_busy,
					burst_busy, dev_idle, 1'b0, state_r};
				OFF_ERR: s_axi_rdata <= {30'h0, cke_viol_r, illegal_r};
				OFF_RENEW: s_axi_rdata <= {16'h0000, renew_cnt_r};
				OFF_CAL: s_axi_rdata <= {15'h0000, init_cal_done_r,
					short_cal_cnt_r, long_cal_cnt_r};
				default:
				begin
					if (s_axi_araddr >= OFF_MR0 && s_axi_araddr <= OFF_MR3
						&& s_axi_araddr[1:0] == 2'h0)
						s_axi_rdata <= {16'h0000, mr_r[s_axi_araddr[3:2]]};
					else
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ===== sdc_cmd_decoder_props.sv
// Concurrent checks on the command decoder top-level ports
`timescale 1ns/100ps
module sdc_cmd_decoder_props
	import sdc_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          mem_reset_n,
	input wire sdc_event_type cmd_event,
	input wire sdc_state_type dev_state,
	input wire logic          dev_idle,
	input wire logic [7:0]    s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic [1:0]    s_axi_rresp,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready
);
	default clocking cb @(posedge aclk); endclocking
	// Device reset clears state at once, so checks pause with it too
	default disable iff (!aresetn || !mem_reset_n);

	sequence s_ev(sdc_cmd_type c);
		cmd_event.valid && cmd_event.legal && cmd_event.cmd == c;
	endsequence
	sequence s_rw;
		cmd_event.valid && cmd_event.legal &&
			cmd_event.cmd inside {CMD_READ, CMD_WRITE};
	endsequence
	sequence s_no_rw;
		!(cmd_event.valid && cmd_event.legal &&
			cmd_event.cmd inside {CMD_READ, CMD_WRITE});
	endsequence

	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rd_err;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40 |=>
			s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> ##1 s_axi_bvalid;
	endproperty
	property p_burst;
		s_rw |=> s_no_rw;
	endproperty
	property p_quiet;
		cmd_event.valid && cmd_event.cmd inside {CMD_IDLE, CMD_UNSELECTED}
			|-> $stable(dev_state);
	endproperty
	property p_pd_enter;
		s_ev(CMD_LOW_POWER_ENTRY) |->
			dev_state inside {ST_PD_ACTIVE, ST_PD_PRECHARGE};
	endproperty
	property p_sr_enter;
		s_ev(CMD_SLEEP_ENTRY) |-> dev_state == ST_SELF_RENEW && !dev_idle;
	endproperty
	property p_exit;
		s_ev(CMD_LOW_POWER_EXIT) or s_ev(CMD_SLEEP_EXIT) |->
			dev_state inside {ST_IDLE, ST_ACTIVE};
	endproperty
	property p_no_renew;
		dev_state inside {ST_PD_ACTIVE, ST_PD_PRECHARGE, ST_SELF_RENEW} |->
			!(cmd_event.valid && cmd_event.cmd == CMD_AUTO_RENEW);
	endproperty
	property p_idle;
		dev_idle |-> dev_state == ST_IDLE;
	endproperty
	property p_act;
		s_ev(CMD_ROW_OPEN) |-> dev_state == ST_ACTIVE && !dev_idle;
	endproperty

	a_rd_hold: assert property (p_rd_hold) else $error("rvalid dropped");
	a_wr_hold: assert property (p_wr_hold) else $error("bvalid dropped");
	a_rd_err: assert property (p_rd_err) else $error("bad unmapped read");
	a_wr_resp: assert property (p_wr_resp) else $error("no write reply");
	a_burst: assert property (p_burst) else $error("burst cut");
	a_quiet: assert property (p_quiet) else $error("idle moved");
	a_pd_enter: assert property (p_pd_enter) else $error("pd entry");
	a_sr_enter: assert property (p_sr_enter) else $error("sr entry");
	a_exit: assert property (p_exit) else $error("exit state");
	a_no_renew: assert property (p_no_renew) else $error("pd renew");
	a_idle: assert property (p_idle) else $error("idle flag");
	a_act: assert property (p_act) else $error("row open");
endmodule

bind sdc_cmd_decoder sdc_cmd_decoder_props sdc_cmd_decoder_props_inst (
	.aclk, .aresetn, .mem_reset_n, .cmd_event, .dev_state, .dev_idle,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready
);

// ===== sdc_ctrl_model.sv
// Memory controller model driving the decoder's command pins
`timescale 1ns/100ps
module sdc_ctrl_model
	import sdc_pkg::*;
(
	input  wire logic    aclk,
	output sdc_pins_type pins
);
	initial
	begin
		pins = '0;
		pins.chip_sel_n = 1'b1;
		pins.clock_gate_input = 1'b1;
	end

	// Nibble is {select, row, column, write}; caller spaces cke changes
	task automatic send(input logic cke, input logic [3:0] c,
		input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
		@(posedge aclk);
		pins.clock_gate_input <= cke;
		{pins.chip_sel_n, pins.row_strobe_n, pins.col_strobe_n,
			pins.write_strobe_n} <= c;
		pins.bnk_sel <= b;
		pins.addr <= a;
		@(posedge aclk);
		{pins.chip_sel_n, pins.row_strobe_n, pins.col_strobe_n,
			pins.write_strobe_n} <= 4'h7;
		// Lines keep a defined level but never the last one
		pins.bnk_sel <= ~b;
		pins.addr <= ~a;
	endtask

	task automatic term(input logic v);
		@(posedge aclk);
		pins.termination_ctrl <= v;
	endtask
endmodule

// ===== sdc_pkg.sv
// Shared constants, command and state types for the command decoder
package sdc_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int BANK_W        = 3;
	localparam int ADDR_W        = 16;
	localparam int BANK_CNT      = 8;
	localparam int MR_CNT        = 4;

	// Busy windows; least times round up to whole cycles
	localparam int REFRESH_NS  = 160;
	localparam int REFRESH_CYC =
		(REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_NS     = 24;
	localparam int EXIT_CYC    = (EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BL8_CYC     = 4;
	localparam int BC4_CYC     = 2;
	localparam int CKE_MIN_EDGES = 3;
	localparam int TMR_W       = 4;

	// Address pin positions
	localparam int AUTOCLOSE_BIT = 10;
	localparam int CHOP_BIT      = 12;

	// Burst-length field of mode word zero
	localparam int          BL_LSB      = 0;
	localparam logic [1:0]  BL_FIXED8   = 2'h0;
	localparam logic [1:0]  BL_PER_CMD  = 2'h1;
	localparam logic [1:0]  BL_FIXED4   = 2'h2;
	localparam logic [15:0] MR_RESET    = 16'h0000;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_ERR     = 8'h08;
	localparam logic [7:0] OFF_RENEW   = 8'h0C;
	localparam logic [7:0] OFF_CAL     = 8'h10;
	localparam logic [7:0] OFF_MR0     = 8'h20;
	localparam logic [7:0] OFF_MR3     = 8'h2C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		CMD_MODE_REG_LOAD,
		CMD_AUTO_RENEW,
		CMD_ROW_CLOSE_ONE,
		CMD_ROW_CLOSE_ALL,
		CMD_ROW_OPEN,
		CMD_WRITE,
		CMD_READ,
		CMD_LONG_CAL,
		CMD_SHORT_CAL,
		CMD_IDLE,
		CMD_UNSELECTED,
		CMD_SLEEP_ENTRY,
		CMD_SLEEP_EXIT,
		CMD_LOW_POWER_ENTRY,
		CMD_LOW_POWER_EXIT
	} sdc_cmd_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_PD_ACTIVE,
		ST_PD_PRECHARGE,
		ST_SELF_RENEW
	} sdc_state_type;

	typedef struct packed {
		logic              chip_sel_n;
		logic              row_strobe_n;
		logic              col_strobe_n;
		logic              write_strobe_n;
		logic              clock_gate_input;
		logic              termination_ctrl;
		logic [BANK_W-1:0] bnk_sel;
		logic [ADDR_W-1:0] addr;
	} sdc_pins_type;

	// Deselected bus with clock enable high: where the pin sampler starts
	localparam sdc_pins_type PIN_IDLE = '{chip_sel_n: 1'b1,
		row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_strobe_n: 1'b1,
		clock_gate_input: 1'b1, default: '0};

	typedef struct packed {
		logic              valid;
		logic              legal;
		sdc_cmd_type       cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic              eight_beat;
	} sdc_event_type;

endpackage

// ===== sdc_sync.sv
// Two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/100ps
module sdc_sync
	import sdc_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ===== sdc_timer.sv
// Loadable down-counter that reports a busy window and its end
`timescale 1ns/100ps
module sdc_timer
	import sdc_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             mem_reset_n,
	input  wire logic             start,
	input  wire logic [TMR_W-1:0] load,
	output logic                  busy,
	output logic                  done
);

	logic [TMR_W-1:0] cnt_r;

	always_ff @(posedge aclk or negedge mem_reset_n)
	begin
		if (!mem_reset_n)
		begin
			cnt_r <= '0;
			done  <= 1'b0;
		end
		else if (!aresetn)
		begin
			cnt_r <= '0;
			done  <= 1'b0;
		end
		else
		begin
			done <= (cnt_r == TMR_W'(1)) && !start;
			if (start)
				cnt_r <= load;
			else if (cnt_r != '0)
				cnt_r <= cnt_r - TMR_W'(1);
		end
	end

	assign busy = (cnt_r != '0);

endmodule

// ===== tb_top.sv
// Self-checking bench for the command decoder
`timescale 1ns/100ps
module tb_top
	import sdc_pkg::*;
;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic          mem_reset_n = 1'b0;
	sdc_pins_type  pins;
	sdc_event_type cmd_event, last_ev;
	sdc_state_type dev_state;
	logic          dev_idle, awready, wready, bvalid, arready, rvalid;
	logic [7:0]    awaddr = 8'h0, araddr = 8'h0;
	logic [31:0]   wdata = 32'h0, rdata, rd_d;
	logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic          arvalid = 1'b0, rready = 1'b0;
	logic [1:0]    bresp, rresp, rd_r, wr_r;
	logic [1:0]    modes[3] = '{BL_FIXED8, BL_PER_CMD, BL_FIXED4};
	logic [1:0]    bexp[3] = '{2'h3, 2'h2, 2'h0};
	int            num_errors = 0;
	int            comparisons = 0;
	int            rw_cnt = 0;
	int            n;

	always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

	sdc_ctrl_model sdc_ctrl_model_inst (.aclk(aclk), .pins(pins));
	sdc_cmd_decoder sdc_cmd_decoder_inst (
		.aclk(aclk), .aresetn(aresetn), .mem_reset_n(mem_reset_n),
		.chip_sel_n(pins.chip_sel_n), .row_strobe_n(pins.row_strobe_n),
		.col_strobe_n(pins.col_strobe_n),
		.write_strobe_n(pins.write_strobe_n),
		.clock_gate_input(pins.clock_gate_input),
		.termination_ctrl(pins.termination_ctrl), .bnk_sel(pins.bnk_sel),
		.addr(pins.addr), .cmd_event(cmd_event), .dev_state(dev_state),
		.dev_idle(dev_idle), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// Events stand one cycle; the falling edge sees them settled
	always @(negedge aclk)
		if (cmd_event.valid && cmd_event.legal &&
			!(cmd_event.cmd inside {CMD_IDLE, CMD_UNSELECTED}))
		begin
			last_ev = cmd_event;
			if (cmd_event.cmd inside {CMD_READ, CMD_WRITE})
				rw_cnt++;
		end

	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask

	// Handshakes are judged at the falling edge, where values equal
	// what the next rising edge samples
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb)
		begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			wr_r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a);
		logic ha, hr;
		hr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hr)
		begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid;
			rd_d = rdata;
			rd_r = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end
	endtask

	// Six edges cover pin delay and event, and keep cke spacing legal
	task automatic do_cmd(input logic cke, input logic [3:0] c,
		input logic [2:0] b, input logic [15:0] a);
		sdc_ctrl_model_inst.send(cke, c, b, a);
		repeat (6) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		mem_reset_n <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(OFF_CTRL);
		check("ctrl", rd_d, CTRL_RESET);
		rd(8'h40);
		check("unmapped", rd_r, RESP_SLVERR);
		wr(OFF_STATUS, 32'hF);
		check("status_ro", wr_r, RESP_SLVERR);
		for (int i = 0; i < 4; i++)
			do_cmd(1'b1, 4'h0, 3'(i), 16'(16'h0100 + i));
		for (int i = 0; i < 4; i++)
		begin
			rd(OFF_MR0 + 8'(4 * i));
			check("mode_reg", rd_d, 32'(16'h0100 + i));
		end
		for (int m = 0; m < 3; m++)
		begin
			do_cmd(1'b1, 4'h0, 3'h0, 16'(modes[m]));
			do_cmd(1'b1, 4'h3, 3'h3, 16'h0055);
			check("act_state", dev_state, ST_ACTIVE);
			for (int k = 0; k < 2; k++)
			begin
				do_cmd(1'b1, 4'h5, 3'h3, 16'(k << CHOP_BIT));
				check("rd_cmd", last_ev.cmd, CMD_READ);
				check("beat", last_ev.eight_beat, bexp[m][k]);
			end
			rd(OFF_STATUS);
			check("bank_open", rd_d[19:12], 8'h08);
			do_cmd(1'b1, 4'h2, 3'h0, 16'h0400);
			check("close_all", dev_state, ST_IDLE);
			check("idle", dev_idle, 1'b1);
		end
		do_cmd(1'b1, 4'h3, 3'h1, 16'h0011);
		n = rw_cnt;
		sdc_ctrl_model_inst.send(1'b1, 4'h5, 3'h1, 16'h0000);
		do_cmd(1'b1, 4'h4, 3'h1, 16'h0000);
		check("burst_keep", rw_cnt - n, 1);
		do_cmd(1'b1, 4'h4, 3'h1, 16'h0000);
		check("wr_cmd", last_ev.cmd, CMD_WRITE);
		do_cmd(1'b1, 4'h2, 3'h0, 16'h0400);
		do_cmd(1'b1, 4'h1, 3'h0, 16'h0000);
		rd(OFF_RENEW);
		check("renew", rd_d, 32'h1);
		do_cmd(1'b0, 4'h7, 3'h0, 16'h0000);
		check("pd_pre", dev_state, ST_PD_PRECHARGE);
		do_cmd(1'b0, 4'h1, 3'h0, 16'h0000);
		do_cmd(1'b1, 4'h7, 3'h0, 16'h0000);
		check("pd_exit", dev_state, ST_IDLE);
		rd(OFF_RENEW);
		check("pd_renew", rd_d, 32'h1);
		do_cmd(1'b1, 4'h3, 3'h2, 16'h0022);
		do_cmd(1'b0, 4'h8, 3'h0, 16'h0000);
		check("pd_act", dev_state, ST_PD_ACTIVE);
		do_cmd(1'b1, 4'h7, 3'h0, 16'h0000);
		check("pd_act_exit", dev_state, ST_ACTIVE);
		do_cmd(1'b1, 4'h2, 3'h0, 16'h0400);
		do_cmd(1'b0, 4'h1, 3'h0, 16'h0000);
		check("sr", dev_state, ST_SELF_RENEW);
		check("sr_idle", dev_idle, 1'b0);
		do_cmd(1'b1, 4'h8, 3'h0, 16'h0000);
		check("sr_exit", dev_state, ST_IDLE);
		sdc_ctrl_model_inst.term(1'b1);
		do_cmd(1'b1, 4'h7, 3'h0, 16'h0000);
		rd(OFF_STATUS);
		check("term", rd_d[8:0], {1'b1, 8'h10});
		sdc_ctrl_model_inst.term(1'b0);
		do_cmd(1'b1, 4'h6, 3'h0, 16'h0400);
		do_cmd(1'b1, 4'h6, 3'h0, 16'h0400);
		do_cmd(1'b1, 4'h6, 3'h0, 16'h0000);
		rd(OFF_CAL);
		check("cal", rd_d, 32'h0001_0101);
		do_cmd(1'b1, 4'h8, 3'h2, 16'hBEEF);
		do_cmd(1'b1, 4'h7, 3'h2, 16'hBEEF);
		rd(OFF_MR0 + 8'h08);
		check("unsel", rd_d, 32'h0102);
		sdc_ctrl_model_inst.send(1'b0, 4'h7, 3'h0, 16'h0000);
		do_cmd(1'b1, 4'h7, 3'h0, 16'h0000);
		rd(OFF_ERR);
		check("cke_hold", rd_d[1], 1'b1);
		wr(OFF_ERR, 32'h3);
		check("err_wr", wr_r, RESP_OKAY);
		rd(OFF_ERR);
		check("err_clr", rd_d, 32'h0);
		wr(OFF_CTRL, 32'h0);
		check("ctrl_wr", wr_r, RESP_OKAY);
		do_cmd(1'b1, 4'h3, 3'h4, 16'h0044);
		check("ctrl_off", dev_state, ST_IDLE);
		wr(OFF_CTRL, CTRL_RESET);
		@(posedge aclk);
		mem_reset_n <= 1'b0;
		@(posedge aclk);
		mem_reset_n <= 1'b1;
		rd(OFF_MR0 + 8'h08);
		check("mr_reset", rd_d, 32'h0);
		rd(OFF_RENEW);
		check("renew_reset", rd_d, 32'h0);
		print_verdict();
	end
endmodule
